// ### rtl/bal_datapath.sv
// Byte arithmetic and logic datapath with its own working register file
// and status flags. Assumes the decoder waits for done_o before the next request.
`timescale 1ns/10ps

// Function
// - Add puts dest+src in dest, carry form adds C; Z,C,N,V,H; 1 cycle.
// - Word add adds a constant to a register pair; Z,C,N,V,S; 2 cycles.
// - Subtract takes register or constant from dest; Z,C,N,V,H; 1 cycle.
// - Subtract with carry also takes C, both forms; Z,C,N,V,H; 1 cycle.
// - Word subtract takes a constant from a pair; Z,C,N,V,S; 2 cycles.
// - AND with register or constant into dest; Z,N,V only; 1 cycle.
// - OR with register or constant, XOR of registers; Z,N,V; 1 cycle.
// - Set-bits ORs an immediate mask into dest; Z,N,V; 1 cycle.
// - Clear-bits ANDs dest with all-ones minus the mask; Z,N,V; 1 cycle.
// - Test ANDs a register with itself, value kept; Z,N,V; 1 cycle.
// - Fractional multiply puts product<<1 in pair 1:0; Z,C; 2 cycles.
module bal_datapath
    import bal_pkg::*;
#(
    parameter int DATA_W = BAL_DATA_W,
    parameter int REG_CNT = BAL_REG_CNT
)
(
    // Clock and reset
    input wire logic clock_i,
    input wire logic rst_n_i,
    // Request from decoder
    input wire logic start_i,
    input wire bal_op_type op_i,
    input wire logic [4:0] dest_i,
    input wire logic [4:0] src_i,
    input wire logic [7:0] imm_i,
    // Status and result
    output logic busy_o,
    output logic done_o,
    output logic [7:0] result_o,
    output logic [5:0] flags_o
);
    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic {BAL_IDLE, BAL_SECOND} bal_state_type;
    bal_state_type state;
    logic [7:0] regs [REG_CNT];
    logic [5:0] flags;
    bal_op_type held_op;
    logic [4:0] held_dest;
    logic mul_raw_msb;
    logic low_carry;
    logic [7:0] low_res;
    logic [15:0] product;

    // ------------------------------------------------------------
    // Operand selection and arithmetic
    // ------------------------------------------------------------
    bal_if link ();
    bal_addsub u_addsub (.port_b(link.core));

    logic [7:0] rd;
    logic [7:0] rr;
    logic is_word_high;
    logic is_sub;
    logic use_imm;
    logic with_carry;
    logic [15:0] mul_raw;
    logic [16:0] mul_shift;
    logic signed [8:0] sa;
    logic signed [8:0] sb;
    logic signed [17:0] sprod;

    assign is_word_high = (state == BAL_SECOND);
    assign rd = is_word_high ? regs[held_dest + 5'h01] : regs[dest_i];
    assign rr = regs[src_i];

    always_comb
    begin
        is_sub = 1'b0;
        use_imm = 1'b0;
        with_carry = 1'b0;
        unique case (op_i)
            BAL_OP_ADD_CARRY: with_carry = 1'b1;
            BAL_OP_WORD_ADD_IMMEDIATE: use_imm = 1'b1;
            BAL_OP_SUB: is_sub = 1'b1;
            BAL_OP_SUBTRACT_IMMEDIATE:
            begin
                is_sub = 1'b1;
                use_imm = 1'b1;
            end
            BAL_OP_SUBTRACT_WITH_CARRY:
            begin
                is_sub = 1'b1;
                with_carry = 1'b1;
            end
            BAL_OP_SUBTRACT_CARRY_IMMEDIATE:
            begin
                is_sub = 1'b1;
                use_imm = 1'b1;
                with_carry = 1'b1;
            end
            BAL_OP_WORD_SUBTRACT_IMMEDIATE:
            begin
                is_sub = 1'b1;
                use_imm = 1'b1;
            end
            default: ;
        endcase
    end

    // Upper word half adds zero plus the low-half carry or borrow
    assign link.op_a = rd;
    assign link.op_b = is_word_high ? BAL_ZERO : (use_imm ? imm_i : rr);
    assign link.subtract = is_word_high
        ? (held_op == BAL_OP_WORD_SUBTRACT_IMMEDIATE) : is_sub;
    assign link.carry_in = is_word_high ? low_carry
        : (with_carry & flags[BAL_FLAG_C]);

    // Signedness per fractional multiply flavour
    always_comb
    begin
        sa = {1'b0, rd};
        sb = {1'b0, rr};
        if (op_i == BAL_OP_FRACTIONAL_SIGNED_MULTIPLY)
        begin
            sa = {rd[7], rd};
            sb = {rr[7], rr};
        end
        else if (op_i == BAL_OP_FRACTIONAL_MIXED_MULTIPLY)
        begin
            sa = {rd[7], rd};
        end
        sprod = sa * sb;
    end
    assign mul_raw = sprod[15:0];
    assign mul_shift = {mul_raw, 1'b0};

    // ------------------------------------------------------------
    // Byte result for single-cycle operations
    // ------------------------------------------------------------
    logic [7:0] next_res;
    logic logic_op;
    logic arith_op;
    always_comb
    begin
        next_res = link.result;
        logic_op = 1'b1;
        arith_op = 1'b0;
        unique case (op_i)
            BAL_OP_AND, BAL_OP_AND_IMMEDIATE:
                next_res = rd & (op_i == BAL_OP_AND ? rr : imm_i);
            BAL_OP_OR, BAL_OP_OR_IMMEDIATE:
                next_res = rd | (op_i == BAL_OP_OR ? rr : imm_i);
            BAL_OP_EXCLUSIVE_OR: next_res = rd ^ rr;
            BAL_OP_SET_MASK_BITS: next_res = rd | imm_i;
            BAL_OP_CLEAR_MASK_BITS:
                next_res = rd & (BAL_ALL_ONES - imm_i);
            BAL_OP_ZERO_MINUS_TEST: next_res = rd & rd;
            BAL_OP_ADD, BAL_OP_ADD_CARRY, BAL_OP_SUB,
            BAL_OP_SUBTRACT_IMMEDIATE, BAL_OP_SUBTRACT_WITH_CARRY,
            BAL_OP_SUBTRACT_CARRY_IMMEDIATE:
            begin
                logic_op = 1'b0;
                arith_op = 1'b1;
            end
            default: logic_op = 1'b0;
        endcase
    end

    logic is_word;
    logic is_mul;
    assign is_word = (op_i == BAL_OP_WORD_ADD_IMMEDIATE)
        || (op_i == BAL_OP_WORD_SUBTRACT_IMMEDIATE);
    assign is_mul = (op_i == BAL_OP_FRACTIONAL_MULTIPLY)
        || (op_i == BAL_OP_FRACTIONAL_SIGNED_MULTIPLY)
        || (op_i == BAL_OP_FRACTIONAL_MIXED_MULTIPLY);

    // ------------------------------------------------------------
    // Sequencing: two-cycle operations use a second state
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            state <= BAL_IDLE;
        else if (state == BAL_IDLE && start_i && (is_word || is_mul))
            state <= BAL_SECOND;
        else
            state <= BAL_IDLE;
    end

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            held_op <= BAL_OP_ADD;
            held_dest <= BAL_PROD_LO;
            low_carry <= 1'b0;
            low_res <= BAL_ZERO;
            product <= 16'h0000;
        end
        else if (state == BAL_IDLE && start_i)
        begin
            held_op <= op_i;
            held_dest <= dest_i;
            low_carry <= link.carry_out;
            low_res <= link.result;
            product <= mul_shift[15:0];
        end
    end

    // ------------------------------------------------------------
    // Register file write-back
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            for (int i = 0; i < REG_CNT; i++)
                regs[i] <= BAL_ZERO;
        end
        else if (state == BAL_SECOND)
        begin
            if (held_op == BAL_OP_WORD_ADD_IMMEDIATE
                || held_op == BAL_OP_WORD_SUBTRACT_IMMEDIATE)
            begin
                regs[held_dest] <= low_res;
                regs[held_dest + 5'h01] <= link.result;
            end
            else
            begin
                regs[BAL_PROD_LO] <= product[7:0];
                regs[BAL_PROD_HI] <= product[15:8];
            end
        end
        else if (start_i && (logic_op || arith_op))
            regs[dest_i] <= next_res;
    end

    // ------------------------------------------------------------
    // Flags: unlisted flags keep their value
    // ------------------------------------------------------------
    logic [15:0] word_res;
    logic word_v;
    logic word_c;
    assign word_res = {link.result, low_res};
    assign word_v = link.overflow_out;
    assign word_c = link.carry_out;

    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            flags <= BAL_FLAGS_RST;
        else if (state == BAL_SECOND)
        begin
            if (held_op == BAL_OP_WORD_ADD_IMMEDIATE
                || held_op == BAL_OP_WORD_SUBTRACT_IMMEDIATE)
            begin
                flags[BAL_FLAG_Z] <= (word_res == 16'h0000);
                flags[BAL_FLAG_C] <= word_c;
                flags[BAL_FLAG_N] <= link.result[7];
                flags[BAL_FLAG_V] <= word_v;
                flags[BAL_FLAG_S] <= link.result[7] ^ word_v;
            end
            else
            begin
                flags[BAL_FLAG_Z] <= (product == 16'h0000);
                flags[BAL_FLAG_C] <= mul_raw_msb;
            end
        end
        else if (start_i && arith_op)
        begin
            flags[BAL_FLAG_Z] <= (link.result == BAL_ZERO);
            flags[BAL_FLAG_C] <= link.carry_out;
            flags[BAL_FLAG_N] <= link.result[7];
            flags[BAL_FLAG_V] <= link.overflow_out;
            flags[BAL_FLAG_H] <= link.half_out;
        end
        else if (start_i && logic_op)
        begin
            flags[BAL_FLAG_Z] <= (next_res == BAL_ZERO);
            flags[BAL_FLAG_N] <= next_res[7];
            flags[BAL_FLAG_V] <= 1'b0;
        end
    end

    // Carry of a fractional product is the bit shifted out
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            mul_raw_msb <= 1'b0;
        else if (state == BAL_IDLE && start_i)
            mul_raw_msb <= mul_raw[15];
    end

    // ------------------------------------------------------------
    // Outputs, all registered
    // ------------------------------------------------------------
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
        begin
            busy_o <= 1'b0;
            done_o <= 1'b0;
            result_o <= BAL_ZERO;
        end
        else
        begin
            busy_o <= (state == BAL_IDLE) && start_i && (is_word || is_mul);
            done_o <= (state == BAL_SECOND)
                || (state == BAL_IDLE && start_i && (logic_op || arith_op));
            if (state == BAL_SECOND)
                result_o <= (held_op == BAL_OP_WORD_ADD_IMMEDIATE
                    || held_op == BAL_OP_WORD_SUBTRACT_IMMEDIATE)
                    ? link.result : product[15:8];
            else if (start_i && (logic_op || arith_op))
                result_o <= next_res;
        end
    end
    assign flags_o = flags;
endmodule : bal_datapath

// ### rtl/bal_pkg.sv
// Package for the byte arithmetic/logic datapath: opcodes, flag bit
// positions, widths and cycle counts. Assumes nothing else.
package bal_pkg;
    // ------------------------------------------------------------
    // Widths and flag positions
    // ------------------------------------------------------------
    localparam int BAL_DATA_W = 8;
    localparam int BAL_REG_CNT = 32;
    localparam int BAL_REG_AW = 5;
    localparam int BAL_FLAG_C = 0;
    localparam int BAL_FLAG_Z = 1;
    localparam int BAL_FLAG_N = 2;
    localparam int BAL_FLAG_V = 3;
    localparam int BAL_FLAG_S = 4;
    localparam int BAL_FLAG_H = 5;
    localparam int BAL_FLAG_W = 6;
    localparam logic [7:0] BAL_ALL_ONES = 8'hff;
    localparam logic [7:0] BAL_ZERO = 8'h00;
    localparam logic [5:0] BAL_FLAGS_RST = 6'h00;
    localparam logic [4:0] BAL_PROD_LO = 5'h00;
    localparam logic [4:0] BAL_PROD_HI = 5'h01;
    // ------------------------------------------------------------
    // Cycle counts
    // ------------------------------------------------------------
    localparam logic [1:0] BAL_CYC_SINGLE = 2'h1;
    localparam logic [1:0] BAL_CYC_DOUBLE = 2'h2;
    // ------------------------------------------------------------
    // Operations
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        BAL_OP_ADD,
        BAL_OP_ADD_CARRY,
        BAL_OP_WORD_ADD_IMMEDIATE,
        BAL_OP_SUB,
        BAL_OP_SUBTRACT_IMMEDIATE,
        BAL_OP_SUBTRACT_WITH_CARRY,
        BAL_OP_SUBTRACT_CARRY_IMMEDIATE,
        BAL_OP_WORD_SUBTRACT_IMMEDIATE,
        BAL_OP_AND,
        BAL_OP_AND_IMMEDIATE,
        BAL_OP_OR,
        BAL_OP_OR_IMMEDIATE,
        BAL_OP_EXCLUSIVE_OR,
        BAL_OP_SET_MASK_BITS,
        BAL_OP_CLEAR_MASK_BITS,
        BAL_OP_ZERO_MINUS_TEST,
        BAL_OP_FRACTIONAL_MULTIPLY,
        BAL_OP_FRACTIONAL_SIGNED_MULTIPLY,
        BAL_OP_FRACTIONAL_MIXED_MULTIPLY
    } bal_op_type;
endpackage : bal_pkg

// ### rtl/bal_if.sv
// Interface carrying one operand/result pair between the datapath
// top and its byte arithmetic core. Assumes one clock domain.
`timescale 1ns/10ps
interface bal_if;
    import bal_pkg::*;
    logic [7:0] op_a;
    logic [7:0] op_b;
    logic carry_in;
    logic subtract;
    logic [7:0] result;
    logic carry_out;
    logic half_out;
    logic overflow_out;
    modport core
    (
        input op_a,
        input op_b,
        input carry_in,
        input subtract,
        output result,
        output carry_out,
        output half_out,
        output overflow_out
    );
    modport user
    (
        output op_a,
        output op_b,
        output carry_in,
        output subtract,
        input result,
        input carry_out,
        input half_out,
        input overflow_out
    );
endinterface : bal_if

// ### rtl/bal_addsub.sv
// Combinational eight-bit adder/subtracter with carry, half carry and
// overflow. Used by the datapath for both byte and word halves.
`timescale 1ns/10ps
module bal_addsub
    import bal_pkg::*;
(
    bal_if.core port_b
);
    logic [7:0] operand;
    logic [8:0] wide;
    logic [4:0] low;
    logic cin;

    // Subtraction is done as a + ~b + ~borrow; carry then means borrow
    assign operand = port_b.subtract ? ~port_b.op_b : port_b.op_b;
    assign cin = port_b.subtract ? ~port_b.carry_in : port_b.carry_in;
    assign wide = {1'b0, port_b.op_a} + {1'b0, operand} + {8'h00, cin};
    assign low = {1'b0, port_b.op_a[3:0]} + {1'b0, operand[3:0]}
        + {4'h0, cin};
    assign port_b.result = wide[7:0];
    assign port_b.carry_out = port_b.subtract ? ~wide[8] : wide[8];
    assign port_b.half_out = port_b.subtract ? ~low[4] : low[4];
    assign port_b.overflow_out = (port_b.op_a[7] == operand[7])
        && (wide[7] != port_b.op_a[7]);
endmodule : bal_addsub

// ### tb/bal_decoder_model.sv
// Decoder stand-in: issues one request at a time to the datapath.
// Assumes the datapath owns the register file and flag register.
`timescale 1ns/10ps
module bal_decoder_model
    import bal_pkg::*;
(
    // Clock
    input wire logic clock_i,
    // Request out
    output logic start_o,
    output bal_op_type op_o,
    output logic [4:0] dest_o,
    output logic [4:0] src_o,
    output logic [7:0] imm_o,
    // Answer in
    input wire logic done_i,
    input wire logic [7:0] result_i,
    input wire logic [5:0] flags_i
);
    logic ok;
    logic [7:0] res;
    logic [5:0] flg;
    initial
    begin
        start_o = 1'b0;
        op_o = BAL_OP_ADD;
        dest_o = 5'h00;
        src_o = 5'h00;
        imm_o = 8'h00;
    end
    // Hold keeps start up into the second cycle, where it must be ignored
    task automatic run_op(input bal_op_type o, input logic [4:0] d,
        input logic [4:0] s, input logic [7:0] k, input logic hold);
        int n;
        @(posedge clock_i);
        start_o <= 1'b1;
        op_o <= o;
        dest_o <= d;
        src_o <= s;
        imm_o <= k;
        @(posedge clock_i);
        if (hold)
        begin
            @(posedge clock_i);
        end
        start_o <= 1'b0;
        n = 0;
        #1;
        while (done_i !== 1'b1 && n < 4)
        begin
            @(posedge clock_i);
            #1;
            n++;
        end
        ok = (done_i === 1'b1);
        res = result_i;
        flg = flags_i;
    endtask : run_op
endmodule : bal_decoder_model

// ### tb/bal_datapath_sva.sv
// Checker for the datapath top: timing and flag relations.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/10ps
module bal_datapath_sva
    import bal_pkg::*;
#(
    parameter int DATA_W = BAL_DATA_W,
    parameter int REG_CNT = BAL_REG_CNT
)
(
    input wire logic clock_i,
    input wire logic rst_n_i,
    input wire logic start_i,
    input wire bal_op_type op_i,
    input wire logic [4:0] dest_i,
    input wire logic [4:0] src_i,
    input wire logic [7:0] imm_i,
    input wire logic busy_o,
    input wire logic done_o,
    input wire logic [7:0] result_o,
    input wire logic [5:0] flags_o
);
    default clocking cb @(posedge clock_i); endclocking
    default disable iff (!rst_n_i);
    logic second_q;
    logic take;
    logic wd;
    logic ml;
    logic lg;
    assign take = start_i && !second_q;
    assign wd = op_i inside {BAL_OP_WORD_ADD_IMMEDIATE,
        BAL_OP_WORD_SUBTRACT_IMMEDIATE};
    assign ml = op_i inside {BAL_OP_FRACTIONAL_MULTIPLY,
        BAL_OP_FRACTIONAL_SIGNED_MULTIPLY, BAL_OP_FRACTIONAL_MIXED_MULTIPLY};
    assign lg = op_i inside {BAL_OP_AND, BAL_OP_AND_IMMEDIATE, BAL_OP_OR,
        BAL_OP_OR_IMMEDIATE, BAL_OP_EXCLUSIVE_OR, BAL_OP_SET_MASK_BITS,
        BAL_OP_CLEAR_MASK_BITS, BAL_OP_ZERO_MINUS_TEST};
    // Second cycle of a two-cycle op refuses any start
    always_ff @(posedge clock_i)
    begin
        if (!rst_n_i)
            second_q <= 1'b0;
        else
            second_q <= take && (wd || ml);
    end
    chk_single_done: assert property (take && !(wd || ml) |->
        ##1 done_o)
        else $error("single-cycle op did not finish in one cycle");
    chk_double_timing: assert property (take && (wd || ml) |->
        ##1 (busy_o && !done_o) ##1 done_o)
        else $error("two-cycle op timing wrong");
    chk_logic_clear_v: assert property (take && lg |->
        ##1 !flags_o[3])
        else $error("logic op left overflow set");
    chk_logic_zero_neg: assert property (take && lg |-> ##1
        flags_o[1] == (result_o == 8'h00) && flags_o[2] == result_o[7])
        else $error("logic op zero or negative flag wrong");
    chk_logic_flags_hold: assert property (take && lg |-> ##1
        {flags_o[5:4], flags_o[0]} == {$past(flags_o[5:4]), $past(flags_o[0])})
        else $error("logic op changed an unlisted flag");
    chk_word_sign: assert property (take && wd |->
        ##2 flags_o[4] == (flags_o[2] ^ flags_o[3]))
        else $error("word op sign flag is not N xor V");
    chk_word_keep_h: assert property (take && wd |->
        ##2 flags_o[5] == $past(flags_o[5], 2))
        else $error("word op changed half carry");
    chk_mul_keep_flags: assert property (take && ml |->
        ##2 flags_o[5:2] == $past(flags_o[5:2], 2))
        else $error("multiply changed a flag other than Z or C");
    chk_reset_quiet: assert property ($rose(rst_n_i) |->
        flags_o == 6'h00 && !done_o && !busy_o)
        else $error("outputs not cleared by reset");
endmodule : bal_datapath_sva
bind bal_datapath bal_datapath_sva #(.DATA_W(DATA_W), .REG_CNT(REG_CNT))
    u_bal_datapath_sva (.clock_i(clock_i), .rst_n_i(rst_n_i),
    .start_i(start_i), .op_i(op_i), .dest_i(dest_i), .src_i(src_i),
    .imm_i(imm_i), .busy_o(busy_o), .done_o(done_o),
    .result_o(result_o), .flags_o(flags_o));

// ### tb/tb_bal_datapath.sv
// Self-checking bench: expected {result, flags} per op, flags C Z N V S H.
// Assumes the register file and flags start at zero after reset.
`timescale 1ns/10ps
module tb_bal_datapath
    import bal_pkg::*;
;
    logic clock_i;
    logic rst_n_i;
    logic start_i;
    bal_op_type op_i;
    logic [4:0] dest_i;
    logic [4:0] src_i;
    logic [7:0] imm_i;
    logic busy_o;
    logic done_o;
    logic [7:0] result_o;
    logic [5:0] flags_o;
    int err_count = 0;
    int n_compared = 0;
    bal_datapath u_bal_datapath (.clock_i(clock_i), .rst_n_i(rst_n_i),
        .start_i(start_i), .op_i(op_i), .dest_i(dest_i), .src_i(src_i),
        .imm_i(imm_i), .busy_o(busy_o), .done_o(done_o),
        .result_o(result_o), .flags_o(flags_o));
    bal_decoder_model u_bal_decoder_model (.clock_i(clock_i),
        .start_o(start_i), .op_o(op_i), .dest_o(dest_i), .src_o(src_i),
        .imm_o(imm_i), .done_i(done_o), .result_i(result_o),
        .flags_i(flags_o));
    initial
    begin
        clock_i = 1'b0;
        forever #20 clock_i = ~clock_i;
    end
    task automatic check(input logic [13:0] seen, input logic [13:0] exp);
        n_compared++;
        if (seen !== exp)
        begin
            err_count++;
            $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task automatic step(input bal_op_type o, input logic [4:0] d,
        input logic [4:0] s, input logic [7:0] k, input logic [13:0] e,
        input logic h = 1'b0);
        u_bal_decoder_model.run_op(o, d, s, k, h);
        if (!u_bal_decoder_model.ok)
            err_count++;
        check({u_bal_decoder_model.res, u_bal_decoder_model.flg}, e);
    endtask : step
    task automatic t_add;
        step(BAL_OP_SET_MASK_BITS, 5'h10, 5'h00, 8'h7f,
            {8'h7f, 6'h00});
        step(BAL_OP_SET_MASK_BITS, 5'h11, 5'h00, 8'h01,
            {8'h01, 6'h00});
        step(BAL_OP_ADD, 5'h10, 5'h11, 8'h00, {8'h80, 6'h2c});
        step(BAL_OP_ADD_CARRY, 5'h10, 5'h10, 8'h00,
            {8'h00, 6'h0b});
        step(BAL_OP_ADD_CARRY, 5'h11, 5'h11, 8'h00,
            {8'h03, 6'h00});
    endtask : t_add
    task automatic t_sub;
        step(BAL_OP_SUB, 5'h11, 5'h10, 8'h00, {8'h03, 6'h00});
        step(BAL_OP_SUBTRACT_IMMEDIATE, 5'h11, 5'h00, 8'h04,
            {8'hff, 6'h25});
        step(BAL_OP_SUBTRACT_WITH_CARRY, 5'h11, 5'h10, 8'h00,
            {8'hfe, 6'h04});
        step(BAL_OP_SUBTRACT_IMMEDIATE, 5'h11, 5'h00, 8'hff,
            {8'hff, 6'h25});
        step(BAL_OP_SUBTRACT_CARRY_IMMEDIATE, 5'h11, 5'h00, 8'h7f,
            {8'h7f, 6'h28});
    endtask : t_sub
    task automatic t_logic;
        step(BAL_OP_AND_IMMEDIATE, 5'h11, 5'h00, 8'hc1,
            {8'h41, 6'h20});
        step(BAL_OP_OR_IMMEDIATE, 5'h11, 5'h00, 8'h80,
            {8'hc1, 6'h24});
        step(BAL_OP_EXCLUSIVE_OR, 5'h11, 5'h11, 8'h00,
            {8'h00, 6'h22});
        step(BAL_OP_SET_MASK_BITS, 5'h10, 5'h00, 8'hf0,
            {8'hf0, 6'h24});
        step(BAL_OP_CLEAR_MASK_BITS, 5'h10, 5'h00, 8'h30,
            {8'hc0, 6'h24});
        step(BAL_OP_ZERO_MINUS_TEST, 5'h11, 5'h00, 8'h00,
            {8'h00, 6'h22});
        step(BAL_OP_OR, 5'h11, 5'h10, 8'h00, {8'hc0, 6'h24});
        step(BAL_OP_AND, 5'h11, 5'h12, 8'h00, {8'h00, 6'h22});
        step(BAL_OP_ZERO_MINUS_TEST, 5'h10, 5'h00, 8'h00,
            {8'hc0, 6'h24});
    endtask : t_logic
    task automatic t_word;
        step(BAL_OP_SET_MASK_BITS, 5'h18, 5'h00, 8'hff,
            {8'hff, 6'h24});
        step(BAL_OP_SET_MASK_BITS, 5'h19, 5'h00, 8'h7f,
            {8'h7f, 6'h20});
        step(BAL_OP_WORD_ADD_IMMEDIATE, 5'h18, 5'h00, 8'h01,
            {8'h80, 6'h2c});
        step(BAL_OP_WORD_SUBTRACT_IMMEDIATE, 5'h18, 5'h00, 8'h01,
            {8'h7f, 6'h38});
        step(BAL_OP_SET_MASK_BITS, 5'h18, 5'h00, 8'h00,
            {8'hff, 6'h34});
    endtask : t_word
    task automatic t_mul;
        step(BAL_OP_FRACTIONAL_MULTIPLY, 5'h10, 5'h10, 8'h00,
            {8'h20, 6'h35});
        step(BAL_OP_FRACTIONAL_SIGNED_MULTIPLY, 5'h10, 5'h10, 8'h00,
            {8'h20, 6'h34});
        step(BAL_OP_FRACTIONAL_MIXED_MULTIPLY, 5'h10, 5'h19, 8'h00,
            {8'hc0, 6'h35});
        step(BAL_OP_SET_MASK_BITS, 5'h00, 5'h00, 8'h00,
            {8'h80, 6'h35});
        step(BAL_OP_SET_MASK_BITS, 5'h01, 5'h00, 8'h00,
            {8'hc0, 6'h35});
    endtask : t_mul
    // A second add would leave 8001 in the pair instead of 8000
    task automatic t_refuse;
        step(BAL_OP_WORD_ADD_IMMEDIATE, 5'h18, 5'h00, 8'h01,
            {8'h80, 6'h2c}, 1'b1);
        step(BAL_OP_SET_MASK_BITS, 5'h18, 5'h00, 8'h00,
            {8'h00, 6'h22});
    endtask : t_refuse
    task automatic t_reset;
        @(posedge clock_i);
        rst_n_i <= 1'b0;
        repeat (2) @(posedge clock_i);
        rst_n_i <= 1'b1;
        #1;
        check({result_o, flags_o}, 14'h0000);
        // Register 16 held c0 before reset, so zero proves it was cleared
        step(BAL_OP_SET_MASK_BITS, 5'h10, 5'h00, 8'h00,
            {8'h00, 6'h02});
    endtask : t_reset
    task automatic stop_test;
        if (err_count == 0 && n_compared > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask : stop_test
    initial
    begin
        rst_n_i = 1'b0;
        repeat (10) @(posedge clock_i);
        rst_n_i <= 1'b1;
        t_add();
        t_sub();
        t_logic();
        t_word();
        t_mul();
        t_refuse();
        t_reset();
        stop_test();
    end
    // Whole run is about 83 cycles; allow about eighteen times that
    initial
    begin
        #60000;
        err_count++;
        stop_test();
    end
endmodule : tb_bal_datapath
